// ---- core/lpm_ctrl.sv ----
`timescale 1ns/100ps
// Overview of operation
// - stop instruction gates oscillator: cpu, timer, serial and spi clocks halt.
// - stop ends only on low interrupt line, low reset pin or power-on reset.
// - timer counter holds in stop and resumes from it after interrupt wake.
// - reset exit from stop loads the timer counter with its reset count.
// - capture edge in stop arms detector; flag and data appear after interrupt wake.
// - reset exit from stop discards any capture armed during stop.
// - serial baud generator halts in stop; transmission resumes after interrupt wake.
// - receiver mid-character at stop entry stops sampling; rest of data lost.
// - master spi baud generator halts in stop; restarts on interrupt or reset wake.
// - reset exit from stop clears spi control/status bits, spi disabled.
// - slave spi keeps shifting during stop with external clock and data.
// - slave transfer done in stop sets no flag until interrupt wake.
// - spi collision and mode fault protection inactive during stop.
// - enabled output drivers keep driving their level through stop.
// - wait instruction halts the cpu clock; peripherals keep running unless serial is switched off.
// - wait ends on timer, serial or spi interrupt, interrupt line, reset pin.
// - timer always runs in wait; serial units may be switched off.
// - non-reset wait exit keeps peripherals; reset exit returns them to reset.
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int TMR_W = LPM_TMR_W
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             stop_req,
  input  wire logic             wait_req,
  input  wire logic             irq_n,
  input  wire logic             reset_pin_n,
  input  wire logic             por,
  input  wire logic             capture_input_pin,
  input  wire logic             capture_rising,
  input  wire logic             timer_irq,
  input  wire logic             serial_irq,
  input  wire logic             spi_irq,
  input  wire logic             spi_master,
  input  wire logic             spi_slave_done,
  input  wire logic             rx_busy,
  input  wire logic             serial_off_in_wait,
  output lpm_state_t            power_state,
  output lpm_gate_t             clk_gate,
  output logic [TMR_W-1:0]      timer_count,
  output logic                  capture_flag,
  output logic [TMR_W-1:0]      capture_data,
  output logic                  rx_abort,
  output logic                  spi_clear,
  output logic                  spi_flag_set,
  output logic                  spi_protect_en,
  output logic                  output_hold,
  output logic                  periph_reset
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [LPM_SYNC_W-1:0] pins_raw;
  logic [LPM_SYNC_W-1:0] pins_sync;
  lpm_wake_t             wake;
  logic                  cap_pin_raw;
  logic                  cap_pin_sync;
  logic                  cap_pin_prev;
  logic                  next_cap_pin_prev;
  logic                  cap_edge;

  assign pins_raw = {~irq_n, ~reset_pin_n, por};

  lpm_sync #(.WIDTH(LPM_SYNC_W)) u_sync_pins (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  assign wake        = lpm_wake_t'(pins_sync);
  assign cap_pin_raw = capture_input_pin;

  lpm_sync #(.WIDTH(1)) u_sync_cap (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (cap_pin_raw),
    .sync_out (cap_pin_sync)
  );

  assign next_cap_pin_prev = cap_pin_sync;
  // valid edge selected by the configured polarity
  assign cap_edge = capture_rising ? (cap_pin_sync & ~cap_pin_prev)
                                   : (~cap_pin_sync & cap_pin_prev);

  // ************************************************************
  // power state machine
  // ************************************************************
  lpm_state_t state;
  lpm_state_t next_state;
  logic       rst_wake;
  logic       irq_wake;
  logic       periph_wake;
  logic       enter_stop;
  logic       stop_irq_exit;
  logic       reset_exit;

  assign rst_wake    = wake.rst_pin | wake.por;
  assign irq_wake    = wake.irq;
  assign periph_wake = timer_irq | serial_irq | spi_irq;

  always_comb begin
    next_state    = state;
    enter_stop    = 1'b0;
    stop_irq_exit = 1'b0;
    reset_exit    = 1'b0;
    case (state)
      LPM_RUN: begin
        if (rst_wake) begin
          reset_exit = 1'b1;
        end else if (stop_req) begin
          next_state = LPM_STOP;
          enter_stop = 1'b1;
        end else if (wait_req) begin
          next_state = LPM_WAIT;
        end
      end
      LPM_STOP: begin
        if (rst_wake) begin
          next_state = LPM_RUN;
          reset_exit = 1'b1;
        end else if (irq_wake) begin
          next_state    = LPM_RUN;
          stop_irq_exit = 1'b1;
        end
      end
      LPM_WAIT: begin
        if (rst_wake) begin
          next_state = LPM_RUN;
          reset_exit = 1'b1;
        end else if (irq_wake || periph_wake) begin
          next_state = LPM_RUN;
        end
      end
      default: begin
        next_state = LPM_RUN;
      end
    endcase
  end

  // ************************************************************
  // clock gates and peripheral controls
  // ************************************************************
  lpm_gate_t next_clk_gate;
  logic      next_rx_abort;
  logic      next_spi_clear;
  logic      next_spi_protect_en;
  logic      next_output_hold;
  logic      next_periph_reset;

  always_comb begin
    // all gates decoded from next_state
    next_clk_gate.cpu      = (next_state == LPM_RUN);
    next_clk_gate.timer    = (next_state != LPM_STOP);
    next_clk_gate.serial   = (next_state == LPM_RUN) ||
                             ((next_state == LPM_WAIT) && !serial_off_in_wait);
    next_clk_gate.spi_baud = (next_state != LPM_STOP);
    next_rx_abort          = enter_stop & rx_busy;
    next_spi_clear         = reset_exit;
    next_spi_protect_en    = (next_state != LPM_STOP);
    next_output_hold       = (next_state == LPM_STOP);
    next_periph_reset      = reset_exit;
  end

  // ************************************************************
  // timer counter and capture
  // ************************************************************
  logic [TMR_W-1:0] next_timer_count;
  logic             cap_armed;
  logic             next_cap_armed;
  logic [TMR_W-1:0] cap_hold;
  logic [TMR_W-1:0] next_cap_hold;
  logic             next_capture_flag;
  logic [TMR_W-1:0] next_capture_data;

  always_comb begin
    next_timer_count  = timer_count;
    next_cap_armed    = cap_armed;
    next_cap_hold     = cap_hold;
    next_capture_flag = 1'b0;
    next_capture_data = capture_data;
    if (reset_exit) begin
      next_timer_count = LPM_TMR_RESET[TMR_W-1:0];
      next_cap_armed   = 1'b0;
    end else if (state == LPM_STOP) begin
      next_timer_count = timer_count;
      if (cap_edge && !cap_armed) begin
        next_cap_armed = 1'b1;
        next_cap_hold  = timer_count;
      end
      if (stop_irq_exit && (cap_armed || cap_edge)) begin
        next_capture_flag = 1'b1;
        next_capture_data = cap_armed ? cap_hold : timer_count;
        next_cap_armed    = 1'b0;
      end
    end else begin
      next_timer_count = timer_count + LPM_TMR_STEP[TMR_W-1:0];
      if (cap_edge) begin
        next_capture_flag = 1'b1;
        next_capture_data = timer_count;
      end
    end
  end

  // ************************************************************
  // slave spi completion deferred through stop
  // ************************************************************
  logic spi_pend;
  logic next_spi_pend;
  logic next_spi_flag_set;

  always_comb begin
    next_spi_pend     = spi_pend;
    next_spi_flag_set = 1'b0;
    if (reset_exit) begin
      next_spi_pend = 1'b0;
    end else if (state == LPM_STOP) begin
      if (spi_slave_done && !spi_master) begin
        next_spi_pend = 1'b1;
      end
      if (stop_irq_exit && (spi_pend || (spi_slave_done && !spi_master))) begin
        next_spi_flag_set = 1'b1;
        next_spi_pend     = 1'b0;
      end
    end else begin
      next_spi_flag_set = spi_slave_done;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state          <= LPM_RUN;
      power_state    <= LPM_RUN;
      clk_gate       <= '{cpu: 1'b1, timer: 1'b1, serial: 1'b1, spi_baud: 1'b1};
      rx_abort       <= 1'b0;
      spi_clear      <= 1'b0;
      spi_protect_en <= 1'b1;
      output_hold    <= 1'b0;
      periph_reset   <= 1'b0;
      cap_pin_prev   <= 1'b0;
    end else begin
      state          <= next_state;
      power_state    <= next_state;
      clk_gate       <= next_clk_gate;
      rx_abort       <= next_rx_abort;
      spi_clear      <= next_spi_clear;
      spi_protect_en <= next_spi_protect_en;
      output_hold    <= next_output_hold;
      periph_reset   <= next_periph_reset;
      cap_pin_prev   <= next_cap_pin_prev;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_count  <= LPM_TMR_RESET[TMR_W-1:0];
      cap_armed    <= 1'b0;
      cap_hold     <= '0;
      capture_flag <= 1'b0;
      capture_data <= '0;
      spi_pend     <= 1'b0;
      spi_flag_set <= 1'b0;
    end else begin
      timer_count  <= next_timer_count;
      cap_armed    <= next_cap_armed;
      cap_hold     <= next_cap_hold;
      capture_flag <= next_capture_flag;
      capture_data <= next_capture_data;
      spi_pend     <= next_spi_pend;
      spi_flag_set <= next_spi_flag_set;
    end
  end

endmodule : lpm_ctrl

// ---- core/lpm_pkg.sv ----
// ************************************************************
// shared constants and types
// ************************************************************
package lpm_pkg;

  localparam int          LPM_TMR_W      = 16;
  localparam logic [15:0] LPM_TMR_RESET  = 16'hFFFC;
  localparam logic [15:0] LPM_TMR_STEP   = 16'h0001;
  localparam int          LPM_SYNC_W     = 3;

  // power state of the core
  typedef enum logic [1:0] {
    LPM_RUN  = 2'b00,
    LPM_STOP = 2'b01,
    LPM_WAIT = 2'b10
  } lpm_state_t;

  // wake events taken from the pins
  typedef struct packed {
    logic irq;
    logic rst_pin;
    logic por;
  } lpm_wake_t;

  // clock gates handed to the core and peripherals
  typedef struct packed {
    logic cpu;
    logic timer;
    logic serial;
    logic spi_baud;
  } lpm_gate_t;

endpackage : lpm_pkg

// ************************************************************
// two flip-flop synchroniser
// ************************************************************
`timescale 1ns/100ps
module lpm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule : lpm_sync

// ---- tb/lpm_ctrl_properties.sv ----
`timescale 1ns/100ps
// ************************************************************
// power mode checker
// ************************************************************
module lpm_ctrl_properties
  import lpm_pkg::*;
#(
  parameter int TMR_W = LPM_TMR_W
) (
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             stop_req,
  input wire logic             wait_req,
  input wire logic             irq_n,
  input wire logic             reset_pin_n,
  input wire logic             por,
  input wire logic             timer_irq,
  input wire logic             serial_irq,
  input wire logic             spi_irq,
  input wire logic             rx_busy,
  input wire logic             serial_off_in_wait,
  input wire lpm_state_t       power_state,
  input wire lpm_gate_t        clk_gate,
  input wire logic [TMR_W-1:0] timer_count,
  input wire logic             capture_flag,
  input wire logic             rx_abort,
  input wire logic             spi_clear,
  input wire logic             spi_flag_set,
  input wire logic             spi_protect_en,
  input wire logic             output_hold,
  input wire logic             periph_reset
);
  logic [3:0] calm;
  logic       ok;
  // pins quiet over the whole synchroniser depth
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      calm <= 4'h0;
    end else begin
      calm <= {calm[2:0], irq_n & reset_pin_n & ~por};
    end
  end
  assign ok = &{calm, irq_n, reset_pin_n, ~por};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_STOP_ENTRY : assert property (
    stop_req && power_state == LPM_RUN && ok |=> power_state == LPM_STOP
    && clk_gate == 4'h0 && output_hold && !spi_protect_en) else $error("bad stop entry");
  AST_RX_ABORT : assert property (
    stop_req && power_state == LPM_RUN && ok |=> rx_abort == $past(rx_busy))
    else $error("bad receiver abort");
  AST_STOP_FROZEN : assert property (
    power_state == LPM_STOP |=> power_state != LPM_STOP || $stable(timer_count))
    else $error("timer moved in stop");
  AST_STOP_STAYS : assert property (
    power_state == LPM_STOP && ok |=> power_state == LPM_STOP)
    else $error("stop left without wake");
  AST_STOP_QUIET : assert property (
    power_state == LPM_STOP |=> power_state != LPM_STOP || (!capture_flag && !spi_flag_set))
    else $error("flag in stop");
  AST_IRQ_WAKE : assert property (
    power_state == LPM_STOP && $fell(irq_n) |-> ##[1:4] power_state == LPM_RUN)
    else $error("no wake on interrupt line");
  AST_WAKE_TOGETHER : assert property (
    power_state == LPM_STOP ##1 power_state == LPM_RUN |-> clk_gate == 4'hF
    && !output_hold && spi_protect_en) else $error("clocks not restarted together");
  AST_RESET_EXIT : assert property (
    periph_reset |-> timer_count == LPM_TMR_RESET && spi_clear && !capture_flag
    && !spi_flag_set) else $error("bad reset exit");
  AST_WAIT_ENTRY : assert property (
    wait_req && !stop_req && power_state == LPM_RUN && ok |=> power_state == LPM_WAIT
    && !clk_gate.cpu && clk_gate.timer && clk_gate.spi_baud
    && clk_gate.serial == !$past(serial_off_in_wait)) else $error("bad wait entry");
  AST_WAIT_EXIT : assert property (
    power_state == LPM_WAIT && ok && (timer_irq || serial_irq || spi_irq)
    |=> power_state == LPM_RUN && !periph_reset) else $error("wait not ended");
  cover property (power_state == LPM_STOP ##1 power_state == LPM_RUN && capture_flag);
  cover property (power_state == LPM_STOP ##1 periph_reset);
  cover property (power_state == LPM_WAIT ##1 power_state == LPM_RUN);
endmodule : lpm_ctrl_properties
bind lpm_ctrl lpm_ctrl_properties #(.TMR_W(TMR_W)) u_props (.*);

// ---- tb/lpm_far_end.sv ----
`timescale 1ns/100ps
// ************************************************************
// wake sources: interrupt line, reset pin, power-on, timer
// ************************************************************
module lpm_far_end (
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic [1:0] kind,
  input  wire logic [2:0] lag,
  output logic            irq_n,
  output logic            reset_pin_n,
  output logic            por,
  output logic            timer_irq
);
  task automatic drive(input logic on);
    irq_n = !(on && kind == 2'h0);
    reset_pin_n = !(on && kind == 2'h1);
    por = on && kind == 2'h2;
    timer_irq = on && kind == 2'h3;
  endtask : drive
  initial begin
    drive(1'b0);
    forever begin
      @(posedge fire);
      repeat (lag) @(negedge clk);
      drive(1'b1);
      repeat (4) @(negedge clk);
      drive(1'b0);
    end
  end
endmodule : lpm_far_end

// ---- tb/lpm_ctrl_test.sv ----
`timescale 1ns/100ps
// ************************************************************
// power mode controller bench
// ************************************************************
module lpm_ctrl_test
  import lpm_pkg::*;
();
  logic        clk = 1'b0, rstn = 1'b0, stop_req = 1'b0, wait_req = 1'b0, fire = 1'b0;
  logic        capture_input_pin = 1'b0, capture_rising = 1'b1, serial_irq = 1'b0;
  logic        spi_irq = 1'b0, spi_master = 1'b0, spi_slave_done = 1'b0, rx_busy = 1'b0;
  logic        serial_off_in_wait = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [2:0]  lag = 3'h0;
  logic        irq_n, reset_pin_n, por, timer_irq, capture_flag, rx_abort, spi_clear;
  logic        spi_flag_set, spi_protect_en, output_hold, periph_reset;
  logic [15:0] timer_count, capture_data;
  lpm_state_t  power_state;
  lpm_gate_t   clk_gate;
  int          n_errors = 0, check_count = 0, i;

  lpm_ctrl dut (.*);
  lpm_far_end far_end (.*);

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wake(input logic [1:0] k);
    int n;
    kind = k;
    lag = 3'($urandom);
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
    for (n = 0; n < 20 && power_state !== LPM_RUN; n++) @(negedge clk);
    if (n == 20) begin
      n_errors++;
      print_verdict();
    end
  endtask : wake

  task automatic stop_test(input logic [1:0] k, input logic rx, arm, done);
    logic [15:0] held;
    logic        rx_exit;
    rx_exit = (k != 2'h0);
    rx_busy = rx;
    stop_req = 1'b1;
    @(negedge clk);
    stop_req = 1'b0;
    // receiver idle apart from the abort corner
    rx_busy = 1'b0;
    check("state", 16'(power_state), 16'(LPM_STOP));
    check("gate", 16'(clk_gate), 16'h0);
    check("hold", 16'(output_hold), 16'h1);
    check("protect", 16'(spi_protect_en), 16'h0);
    check("rx_abort", 16'(rx_abort), 16'(rx));
    held = timer_count;
    capture_input_pin = arm ~^ capture_rising;
    spi_slave_done = done;
    @(negedge clk);
    spi_slave_done = 1'b0;
    repeat (4) @(negedge clk);
    check("frozen", timer_count, held);
    wake(k);
    check("capflag", 16'(capture_flag), 16'(arm && !rx_exit));
    if (arm && !rx_exit) check("capdata", capture_data, held);
    check("spiflag", 16'(spi_flag_set), 16'(done && !spi_master && !rx_exit));
    if (rx_exit) check("reload", timer_count, LPM_TMR_RESET);
    else check("resume", 16'(timer_count - held <= 16'h1), 16'h1);
    check("clear", 16'({spi_clear, periph_reset}), 16'({2{rx_exit}}));
    check("gate_on", 16'(clk_gate), 16'hF);
    capture_input_pin = !capture_rising;
    repeat (10) @(negedge clk);
    $display("stop test exit %0d done", k);
  endtask : stop_test

  task automatic wait_test(input logic off, input logic [2:0] r);
    logic [15:0] t0;
    serial_off_in_wait = off;
    wait_req = 1'b1;
    @(negedge clk);
    wait_req = 1'b0;
    check("wstate", 16'(power_state), 16'(LPM_WAIT));
    check("wgate", 16'(clk_gate), 16'({1'b0, 1'b1, ~off, 1'b1}));
    t0 = timer_count;
    @(negedge clk);
    check("wtimer", 16'(timer_count != t0), 16'h1);
    if (r == 3'h4) wake(2'h1);
    else if (r < 3'h2) wake(r[0] ? 2'h3 : 2'h0);
    else begin
      serial_irq = !r[0];
      spi_irq = r[0];
      @(negedge clk);
      serial_irq = 1'b0;
      spi_irq = 1'b0;
    end
    check("wexit", 16'(power_state), 16'(LPM_RUN));
    check("wkeep", 16'(periph_reset), 16'(r == 3'h4));
    if (r == 3'h4) check("wreload", timer_count, LPM_TMR_RESET);
    serial_off_in_wait = 1'b0;
    repeat (10) @(negedge clk);
    $display("wait test source %0d done", r);
  endtask : wait_test

  initial begin
    void'($urandom(32'hE9A9E973));
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    stop_test(2'h0, 1'b1, 1'b1, 1'b1);
    stop_test(2'h1, 1'b0, 1'b1, 1'b1);
    stop_test(2'h2, 1'b0, 1'b1, 1'b1);
    for (i = 0; i < 12; i++) begin
      spi_master = 1'($urandom);
      // either capture polarity, pin parked at its idle level
      capture_rising = 1'($urandom);
      capture_input_pin = !capture_rising;
      repeat (4) @(negedge clk);
      stop_test(2'($urandom % 3), 1'b0, 1'($urandom), 1'($urandom));
      wait_test(1'($urandom), 3'($urandom % 5));
    end
    print_verdict();
  end
endmodule : lpm_ctrl_test
